/* File: common/rct_pkg.sv */
// constants for the reload/capture up/down timer
package rct_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CONTROL     = 8'hc8;
   localparam logic [7:0] IDX_MODE        = 8'hc9;
   localparam logic [7:0] IDX_RELOAD_LOW  = 8'hca;
   localparam logic [7:0] IDX_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] IDX_COUNT_LOW   = 8'hcc;
   localparam logic [7:0] IDX_COUNT_HIGH  = 8'hcd;
   localparam logic [7:0] IDX_IRQ_ENABLE  = 8'hce;

   // control register fields
   localparam int CTL_OVERFLOW_FLAG  = 7;
   localparam int CTL_EXT_EVENT_FLAG = 6;
   localparam int CTL_RX_BAUD_SELECT = 5;
   localparam int CTL_TX_BAUD_SELECT = 4;
   localparam int CTL_EXT_TRIG_EN    = 3;
   localparam int CTL_RUN_CONTROL    = 2;
   localparam int CTL_COUNT_SOURCE   = 1;
   localparam int CTL_CAPTURE_RELOAD = 0;

   // mode register fields
   localparam int MOD_CLOCK_OUT_EN   = 1;
   localparam int MOD_DOWN_COUNT_EN  = 0;

   // interrupt enable register field
   localparam int IEN_TIMER          = 0;

   // reset values and counter top value
   localparam logic [7:0]  CONTROL_RESET  = 8'h00;
   localparam logic [1:0]  MODE_RESET     = 2'h0;
   localparam logic [15:0] RELOAD_RESET   = 16'h0000;
   localparam logic [15:0] COUNT_RESET    = 16'h0000;
   localparam logic [15:0] COUNT_TOP      = 16'hffff;

   // oscillator clocks per machine cycle and per state time
   localparam int OSC_PER_MACHINE = 12;
   localparam int OSC_PER_STATE   = 2;
   localparam logic [3:0] MACHINE_LAST = 4'(OSC_PER_MACHINE - 1);
   localparam logic [3:0] STATE_LAST   = 4'(OSC_PER_STATE - 1);

endpackage

/* File: design/rct_timer.sv */
// 16-bit reload/capture up/down timer with avalon-mm register slave
`timescale 1ns/100ps

module rct_timer
   import rct_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic [9:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [3:0]  avs_byteenable,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        external_count_pin,
   input  wire logic        trigger_direction_input,
   input  wire logic        other_timer_overflow,
   output logic             rx_baud_tick,
   output logic             tx_baud_tick,
   output logic             clock_output_enable,
   output logic             timer_irq
);

   function automatic logic reg_hit(input logic [7:0] idx, input logic [7:0] want);
      reg_hit = (idx == want);
   endfunction

   // ---------------- registers ----------------
   logic [7:0]  control_q;
   logic [7:0]  control_d;
   logic [1:0]  mode_q;
   logic [15:0] reload_q;
   logic [15:0] reload_d;
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic        irq_en_q;
   logic [3:0]  machine_div_q;
   logic        state_div_q;
   logic        ext_pin_prev_q;
   logic        trig_prev_q;
   logic        ack_q;
   logic [31:0] readdata_q;

   // ---------------- bus decode ----------------
   wire         bus_req    = avs_read | avs_write;
   wire  [7:0]  bus_idx    = avs_address[9:2];
   wire         bus_wr     = avs_write & ack_q & avs_byteenable[0];
   wire  [7:0]  wbyte      = avs_writedata[7:0];
   wire         wr_control = bus_wr & reg_hit(bus_idx, IDX_CONTROL);
   wire         wr_mode    = bus_wr & reg_hit(bus_idx, IDX_MODE);
   wire         wr_rel_lo  = bus_wr & reg_hit(bus_idx, IDX_RELOAD_LOW);
   wire         wr_rel_hi  = bus_wr & reg_hit(bus_idx, IDX_RELOAD_HIGH);
   wire         wr_cnt_lo  = bus_wr & reg_hit(bus_idx, IDX_COUNT_LOW);
   wire         wr_cnt_hi  = bus_wr & reg_hit(bus_idx, IDX_COUNT_HIGH);
   wire         wr_ien     = bus_wr & reg_hit(bus_idx, IDX_IRQ_ENABLE);

   // one wait state on every access
   assign avs_waitrequest = bus_req & ~ack_q;
   assign avs_readdata    = readdata_q;

   wire  [7:0]  rd_byte =
      reg_hit(bus_idx, IDX_CONTROL)     ? control_q :
      reg_hit(bus_idx, IDX_MODE)        ? {6'h00, mode_q} :
      reg_hit(bus_idx, IDX_RELOAD_LOW)  ? reload_q[7:0] :
      reg_hit(bus_idx, IDX_RELOAD_HIGH) ? reload_q[15:8] :
      reg_hit(bus_idx, IDX_COUNT_LOW)   ? count_q[7:0] :
      reg_hit(bus_idx, IDX_COUNT_HIGH)  ? count_q[15:8] :
      reg_hit(bus_idx, IDX_IRQ_ENABLE)  ? {7'h00, irq_en_q} :
                                          8'h00;

   // ---------------- mode decode ----------------
   wire rx_sel     = control_q[CTL_RX_BAUD_SELECT];
   wire tx_sel     = control_q[CTL_TX_BAUD_SELECT];
   wire baud_mode  = rx_sel | tx_sel;
   wire trig_en    = control_q[CTL_EXT_TRIG_EN];
   wire run        = control_q[CTL_RUN_CONTROL];
   wire ext_source = control_q[CTL_COUNT_SOURCE];
   wire capture_md = control_q[CTL_CAPTURE_RELOAD] & ~baud_mode;
   wire down_en    = mode_q[MOD_DOWN_COUNT_EN];
   wire updown_md  = down_en & ~baud_mode;

   // ---------------- tick generation ----------------
   wire machine_tick = (machine_div_q == MACHINE_LAST);
   wire state_tick   = state_div_q == STATE_LAST[0];
   wire ext_fall     = ext_pin_prev_q & ~external_count_pin;
   wire trig_fall    = trig_prev_q & ~trigger_direction_input;

   // internal rate rises sixfold to state time in baud mode
   wire int_tick     = baud_mode ? state_tick : machine_tick;
   wire src_tick     = ext_source ? ext_fall : int_tick;
   wire count_en     = run & src_tick;

   // ---------------- counting ----------------
   // direction follows the trigger level only in up/down mode
   wire count_up     = ~updown_md | trigger_direction_input;
   wire at_top       = (count_q == COUNT_TOP);
   wire at_reload    = (count_q == reload_q);
   wire overflow     = count_en & count_up & at_top;
   wire underflow    = count_en & ~count_up & at_reload;
   wire roll         = overflow | underflow;

   // trigger falls act only when enabled; up/down mode uses the pin as direction
   wire trig_event   = trig_fall & trig_en & ~updown_md;
   wire trig_reload  = trig_event & ~baud_mode & ~capture_md;
   wire trig_capture = trig_event & ~baud_mode & capture_md;

   always_comb
   begin
      count_d = count_q;
      if (count_en)
      begin
         if (overflow)
            count_d = reload_q;
         else if (underflow)
            count_d = COUNT_TOP;
         else if (count_up)
            count_d = count_q + 16'h0001;
         else
            count_d = count_q - 16'h0001;
      end
      if (trig_reload)
         count_d = reload_q;
      // software access to the counter wins over counting
      if (wr_cnt_lo)
         count_d[7:0] = wbyte;
      if (wr_cnt_hi)
         count_d[15:8] = wbyte;
   end

   always_comb
   begin
      reload_d = reload_q;
      if (trig_capture)
         reload_d = count_q;
      if (wr_rel_lo)
         reload_d[7:0] = wbyte;
      if (wr_rel_hi)
         reload_d[15:8] = wbyte;
   end

   // ---------------- flags ----------------
   wire set_ovf   = roll & ~baud_mode;
   wire set_ext   = (trig_reload | trig_capture)
                  | (trig_fall & trig_en & baud_mode);
   wire tog_ext   = roll & updown_md;

   always_comb
   begin
      control_d = control_q;
      if (wr_control)
         control_d = wbyte;
      // hardware events win over a software clear in the same cycle
      if (set_ovf)
         control_d[CTL_OVERFLOW_FLAG] = 1'b1;
      if (tog_ext)
         control_d[CTL_EXT_EVENT_FLAG] = ~control_q[CTL_EXT_EVENT_FLAG];
      else if (set_ext)
         control_d[CTL_EXT_EVENT_FLAG] = 1'b1;
   end

   // ---------------- outputs ----------------
   wire ovf_flag = control_q[CTL_OVERFLOW_FLAG];
   wire ext_flag = control_q[CTL_EXT_EVENT_FLAG];

   assign rx_baud_tick        = rx_sel ? overflow : other_timer_overflow;
   assign tx_baud_tick        = tx_sel ? overflow : other_timer_overflow;
   assign clock_output_enable = mode_q[MOD_CLOCK_OUT_EN];
   assign timer_irq           = irq_en_q & (ovf_flag | (ext_flag & ~down_en));

   // ---------------- state ----------------
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         control_q <= CONTROL_RESET;
         mode_q    <= MODE_RESET;
         reload_q  <= RELOAD_RESET;
         count_q   <= COUNT_RESET;
         irq_en_q  <= 1'b0;
      end
      else
      begin
         control_q <= control_d;
         reload_q  <= reload_d;
         count_q   <= count_d;
         if (wr_mode)
            mode_q <= wbyte[1:0];
         if (wr_ien)
            irq_en_q <= wbyte[IEN_TIMER];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         machine_div_q <= 4'h0;
         state_div_q   <= 1'b0;
      end
      else
      begin
         machine_div_q <= machine_tick ? 4'h0 : machine_div_q + 4'h1;
         state_div_q   <= ~state_div_q;
      end
   end

   // edge detectors start idle high so reset release makes no false fall
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         ext_pin_prev_q <= 1'b1;
         trig_prev_q    <= 1'b1;
      end
      else
      begin
         ext_pin_prev_q <= external_count_pin;
         trig_prev_q    <= trigger_direction_input;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         ack_q      <= 1'b0;
         readdata_q <= 32'h0000_0000;
      end
      else
      begin
         ack_q <= bus_req & ~ack_q;
         if (avs_read & ~ack_q)
            readdata_q <= {24'h00_0000, rd_byte};
      end
   end

endmodule

/* File: verif/rct_serial_side.sv */
// serial-side model: other timer overflow source and baud tick counters
`timescale 1ns/100ps
module rct_serial_side
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        rx_baud_tick,
   input  wire logic        tx_baud_tick,
   output logic             other_timer_overflow,
   output logic [15:0]      other_cnt,
   output logic [15:0]      rx_cnt,
   output logic [15:0]      tx_cnt
);
   logic [2:0] div_q;
   assign other_timer_overflow = div_q == 3'h6;
   always_ff @(posedge clk_sys)
   begin
      div_q <= (!nrst || other_timer_overflow) ? 3'h0 : div_q + 3'h1;
      other_cnt <= !nrst ? 16'h0 : other_cnt + 16'(other_timer_overflow);
      rx_cnt <= !nrst ? 16'h0 : rx_cnt + 16'(rx_baud_tick);
      tx_cnt <= !nrst ? 16'h0 : tx_cnt + 16'(tx_baud_tick);
   end
endmodule

/* File: verif/rct_timer_sva.sv */
// concurrent checks on the timer register slave and baud outputs
`timescale 1ns/100ps
module rct_timer_sva
   import rct_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        other_timer_overflow,
   input wire logic        rx_baud_tick,
   input wire logic        tx_baud_tick,
   input wire logic        clock_output_enable,
   input wire logic        timer_irq
);
   wire req = avs_read | avs_write;
   wire ack = avs_write & ~avs_waitrequest;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   wait_first_a: assert property ($rose(req) |-> avs_waitrequest) else $error("no wait state");
   one_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest) else $error("wait too long");
   idle_low_a: assert property (!req |-> !avs_waitrequest) else $error("wait while idle");
   upper_zero_a: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read bits set");
   data_stands_a: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
      else $error("read data moved");
   rx_pulse_a: assert property (rx_baud_tick && !other_timer_overflow |=> !rx_baud_tick)
      else $error("receive tick too long");
   tx_pulse_a: assert property (tx_baud_tick && !other_timer_overflow |=> !tx_baud_tick)
      else $error("transmit tick too long");
   oe_write_a: assert property ($changed(clock_output_enable) |-> $past(ack))
      else $error("output enable moved alone");
   irq_clear_a: assert property ($fell(timer_irq) |-> $past(ack))
      else $error("interrupt dropped alone");
endmodule

bind rct_timer rct_timer_sva rct_timer_sva_i (.clk_sys(clk_sys), .nrst(nrst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .other_timer_overflow(other_timer_overflow), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
   .clock_output_enable(clock_output_enable), .timer_irq(timer_irq));

/* File: verif/rct_timer_tb.sv */
// self-checking bench for the reload/capture timer
`timescale 1ns/100ps
module rct_timer_tb
   import rct_pkg::*;
;
   logic        clk_sys, nrst, avs_read, avs_write, pin, trig, oto, rx_baud_tick, tx_baud_tick;
   logic        avs_waitrequest, clock_output_enable, timer_irq;
   logic [9:0]  avs_address;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata;
   logic [15:0] o_cnt, rx_cnt, tx_cnt, o, r, t, own, fwd;
   logic [7:0]  rdv;
   logic [7:0]  bs [2] = '{8'h2c, 8'h1c};
   int          bad_count = 0, checked = 0, cyc = 0;
   rct_timer rct_timer_i (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .external_count_pin(pin),
      .trigger_direction_input(trig), .other_timer_overflow(oto), .rx_baud_tick(rx_baud_tick),
      .tx_baud_tick(tx_baud_tick), .clock_output_enable(clock_output_enable), .timer_irq(timer_irq));
   rct_serial_side rct_serial_side_i (.clk_sys(clk_sys), .nrst(nrst), .rx_baud_tick(rx_baud_tick),
      .tx_baud_tick(tx_baud_tick), .other_timer_overflow(oto), .other_cnt(o_cnt), .rx_cnt(rx_cnt),
      .tx_cnt(tx_cnt));
   initial
   begin
      clk_sys = 0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         bad_count++;
         close_out();
      end
   end
   task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, exp, got);
      end
   endtask
   // one bus access; request held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h0, d};
      avs_read <= !w;
      avs_write <= w;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata[7:0];
      avs_read <= 0;
      avs_write <= 0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      acc(1, idx, d);
   endtask
   task automatic rd(input string n, input logic [7:0] idx, input logic [7:0] exp);
      acc(0, idx, 8'h00);
      chk(n, rdv, exp);
   endtask
   task automatic cnt(input int k);
      repeat (k)
      begin
         pin <= 0;
         repeat (2) @(posedge clk_sys);
         pin <= 1;
         repeat (2) @(posedge clk_sys);
      end
   endtask
   task automatic tfall();
      trig <= 0;
      repeat (2) @(posedge clk_sys);
      trig <= 1;
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic setc(input logic [7:0] lo, input logic [7:0] hi);
      wr(IDX_COUNT_LOW, lo);
      wr(IDX_COUNT_HIGH, hi);
   endtask
   initial
   begin
      nrst = 0; avs_read = 0; avs_write = 0; avs_address = 0; avs_writedata = 0;
      avs_byteenable = 4'h1; pin = 1; trig = 1;
      repeat (6) @(posedge clk_sys);
      nrst <= 1;
      @(posedge clk_sys);
      rd("control", IDX_CONTROL, CONTROL_RESET);
      rd("mode", IDX_MODE, 8'h00);
      rd("unmapped", 8'hff, 8'h00);
      wr(IDX_MODE, 8'h02);
      rd("mode oe", IDX_MODE, 8'h02);
      chk("oe pin", {7'h0, clock_output_enable}, 8'h01);
      wr(IDX_MODE, 8'h00);
      $display("test registers done");
      wr(IDX_IRQ_ENABLE, 8'h01);
      wr(IDX_RELOAD_LOW, 8'h34);
      wr(IDX_RELOAD_HIGH, 8'h12);
      setc(8'hfe, 8'hff);
      wr(IDX_CONTROL, 8'h06);
      cnt(2);
      rd("ovf", IDX_CONTROL, 8'h86);
      chk("irq", {7'h0, timer_irq}, 8'h01);
      rd("cnt lo", IDX_COUNT_LOW, 8'h34);
      rd("cnt hi", IDX_COUNT_HIGH, 8'h12);
      wr(IDX_CONTROL, 8'h02);
      cnt(2);
      rd("stopped", IDX_COUNT_LOW, 8'h34);
      chk("irq off", {7'h0, timer_irq}, 8'h00);
      $display("test overflow done");
      setc(8'h05, 8'h00);
      wr(IDX_CONTROL, 8'h0e);
      tfall();
      rd("trig ctl", IDX_CONTROL, 8'h4e);
      rd("trig lo", IDX_COUNT_LOW, 8'h34);
      chk("ext irq", {7'h0, timer_irq}, 8'h01);
      wr(IDX_CONTROL, 8'h0f);
      setc(8'h21, 8'h43);
      tfall();
      rd("cap ctl", IDX_CONTROL, 8'h4f);
      rd("cap lo", IDX_RELOAD_LOW, 8'h21);
      rd("cap hi", IDX_RELOAD_HIGH, 8'h43);
      rd("cap run", IDX_COUNT_LOW, 8'h21);
      wr(IDX_CONTROL, 8'h07);
      cnt(1);
      tfall();
      rd("no trig", IDX_CONTROL, 8'h07);
      rd("no cap", IDX_RELOAD_LOW, 8'h21);
      $display("test trigger done");
      wr(IDX_CONTROL, 8'h02);
      wr(IDX_MODE, 8'h01);
      wr(IDX_RELOAD_LOW, 8'h10);
      wr(IDX_RELOAD_HIGH, 8'h00);
      setc(8'h11, 8'h00);
      trig <= 0;
      wr(IDX_CONTROL, 8'h06);
      cnt(2);
      rd("under", IDX_CONTROL, 8'hc6);
      rd("under lo", IDX_COUNT_LOW, 8'hff);
      wr(IDX_CONTROL, 8'h46);
      chk("no ext irq", {7'h0, timer_irq}, 8'h00);
      trig <= 1;
      cnt(1);
      rd("updown ovf", IDX_CONTROL, 8'h86);
      rd("updown lo", IDX_COUNT_LOW, 8'h10);
      $display("test updown done");
      wr(IDX_CONTROL, 8'h02);
      wr(IDX_MODE, 8'h00);
      // internal ticks: run stands for exactly 24 edges, so two machine ticks
      setc(8'h00, 8'h00);
      wr(IDX_CONTROL, 8'h04);
      repeat (21) @(posedge clk_sys);
      wr(IDX_CONTROL, 8'h02);
      rd("machine rate", IDX_COUNT_LOW, 8'h02);
      wr(IDX_RELOAD_LOW, 8'hff);
      wr(IDX_RELOAD_HIGH, 8'hff);
      // start at the top so every state tick rolls over
      setc(8'hff, 8'hff);
      foreach (bs[i])
      begin
         o = o_cnt; r = rx_cnt; t = tx_cnt;
         wr(IDX_CONTROL, bs[i]);
         tfall();
         repeat (20) @(posedge clk_sys);
         rd("baud ctl", IDX_CONTROL, bs[i] | 8'h40);
         wr(IDX_CONTROL, 8'h00);
         own = i ? tx_cnt - t : rx_cnt - r;
         fwd = i ? rx_cnt - r : tx_cnt - t;
         chk("fwd", fwd[7:0], 8'(o_cnt - o));
         chk("own fast", {7'h0, own > 16'd8}, 8'h01);
      end
      $display("test baud done");
      close_out();
   end
endmodule
